// >>> hw/wdog_defines.svh
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH

// Core clock rate in MHz
`define WD_CLK_MHZ 250

// Window times in microseconds, typical values
`define WD_POR_DELAY_US 16500
`define WD_IGNORE_US 16000
`define WD_TRIGGER_US 96000
`define WD_LOW_US 8000
`define WD_FILTER_MAX_US 500
`define WD_FILTER_MIN_US 100

// Microseconds to whole clock cycles; every time above is a whole number of cycles
`define WD_US_TO_CYC(t) ((t) * `WD_CLK_MHZ)

// Counter widths: 96 ms is 24,000,000 cycles, 500 us is 125,000 cycles
`define WD_CNT_W 25
`define WD_FLT_W 17

// Output levels
`define WD_OUT_LOW 1'h0
`define WD_OUT_HIGH 1'h1

`endif

// >>> hw/wdog_pkg.sv
package wdog_pkg;
`include "wdog_defines.svh"

  typedef logic [`WD_CNT_W-1:0] cnt_t;
  typedef logic [`WD_FLT_W-1:0] flt_cnt_t;

  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_IGNORE = 3'h1,
    ST_TRIGGER = 3'h2,
    ST_LOW = 3'h3,
    ST_DISABLED = 3'h4
  } wd_state_t;

endpackage

// >>> hw/qualifier_if.sv
`timescale 1ns/1ps
interface qualifier_if;
  logic fall_edge;
  logic disabled;

  modport producer (output fall_edge, output disabled);
  modport consumer (input fall_edge, input disabled);
endinterface

// >>> hw/trigger_qualifier.sv
`timescale 1ns/1ps
module trigger_qualifier
  import wdog_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = `WD_US_TO_CYC(`WD_FILTER_MAX_US)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trigger_pin,
  input wire logic band_pin,
  qualifier_if.producer q
);

  // Two-stage synchronisers, first stage read only by the second
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] next_sync_a;
  logic [1:0] next_sync_b;
  logic trig_prev;
  logic next_trig_prev;
  logic fall_edge;
  logic next_fall_edge;
  logic disabled;
  logic next_disabled;
  flt_cnt_t flt_cnt;
  flt_cnt_t next_flt_cnt;

  always_comb begin
    next_sync_a = {sync_a[0], trigger_pin};
    next_sync_b = {sync_b[0], band_pin};
    next_trig_prev = sync_a[1];
    next_fall_edge = trig_prev & ~sync_a[1];
    next_disabled = disabled;
    next_flt_cnt = '0;
    // A band level that disagrees with the state must persist for the full
    // dead time; any shorter excursion restarts the count
    if (sync_b[1] != disabled) begin
      if (flt_cnt == flt_cnt_t'(FILTER_CYCLES - 1)) begin
        next_disabled = sync_b[1];
      end else begin
        next_flt_cnt = flt_cnt + flt_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      trig_prev <= 1'h0;
      fall_edge <= 1'h0;
      disabled <= 1'h0;
      flt_cnt <= '0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      trig_prev <= next_trig_prev;
      fall_edge <= next_fall_edge;
      disabled <= next_disabled;
      flt_cnt <= next_flt_cnt;
    end
  end

  assign q.fall_edge = fall_edge;
  assign q.disabled = disabled;

endmodule

// >>> hw/window_watchdog.sv
// Contract
// - Power-on release starts ignore, then trigger window
// - Only falling trigger edges restart the window
// - Trigger window is fixed at 96 ms
// - Expired trigger window drives output low
// - After 8 ms low, release and ignore
// - Ignore window of 16 ms precedes trigger
// - Band level on trigger input disables watchdog
// - Disable entry waits a 500 us dead time
// - Same dead time on exit; restart with ignore
// - Level changes under 100 us change nothing
// - Output high when disabled from ignore/trigger
// - Long disable during low: finish pulse, rise
// - Short disable during low: stay low, then ignore
`timescale 1ns/1ps
module window_watchdog
  import wdog_pkg::*;
#(
  parameter int unsigned POR_DELAY_CYCLES = `WD_US_TO_CYC(`WD_POR_DELAY_US),
  parameter int unsigned IGNORE_CYCLES = `WD_US_TO_CYC(`WD_IGNORE_US),
  parameter int unsigned TRIGGER_CYCLES = `WD_US_TO_CYC(`WD_TRIGGER_US),
  parameter int unsigned LOW_CYCLES = `WD_US_TO_CYC(`WD_LOW_US),
  parameter int unsigned FILTER_CYCLES = `WD_US_TO_CYC(`WD_FILTER_MAX_US)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic watchdog_trigger_in,
  input wire logic disable_level_band,
  output logic reset_watchdog_out,
  output logic watchdog_disabled,
  output logic timeout_event,
  output wd_state_t window_state
);

  // True when a window counter sits on the last cycle of a window of the given length
  function automatic logic window_done(input cnt_t count, input int unsigned length);
    window_done = (count == cnt_t'(length - 1));
  endfunction

  qualifier_if qual ();

  trigger_qualifier #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_qualifier (
    .clk(clk),
    .rst(rst),
    .trigger_pin(watchdog_trigger_in),
    .band_pin(disable_level_band),
    .q(qual.producer)
  );

  // State sequence: power-on delay, then ignore and trigger windows.
  // A missed trigger gives a low pulse, then another ignore window.
  // The filtered band takes every state but POR to DISABLED; during POR
  // the delay ends first. Leaving DISABLED always starts an ignore window.
  // A low pulse cut by a disable keeps counting: if the band outlasts it
  // the output rises at the normal pulse end, else when the band is left.
  // Edges outside the trigger window, and rising edges, are ignored.
  // All windows assume a running clock; a stopped clock freezes them.

  // Supervision state and the one counter shared by every window
  wd_state_t state;
  wd_state_t next_state;
  cnt_t cnt;
  cnt_t next_cnt;

  // Output level, and a marker for a low pulse still running while disabled
  logic out_level;
  logic next_out_level;
  logic low_hold;
  logic next_low_hold;

  // Registered status outputs
  logic timeout;
  logic next_timeout;
  logic dis_flag;
  logic next_dis_flag;

  // Events and window ends decoded for the current cycle
  logic band_active;
  logic entry_high;
  logic trigger_edge;
  logic por_end;
  logic ignore_end;
  logic trigger_end;
  logic low_end;

  // True in the states where entering the band leaves the output high
  function automatic logic released_state(input wd_state_t s);
    released_state = (s == ST_IGNORE) || (s == ST_TRIGGER);
  endfunction

  // A trigger edge only counts while a trigger window runs
  always_comb begin
    band_active = qual.disabled;
    entry_high = band_active && released_state(state);
    trigger_edge = qual.fall_edge && (state == ST_TRIGGER);
  end

  // Every window compares against the one counter, so the compares are shared
  always_comb begin
    por_end = window_done(cnt, POR_DELAY_CYCLES);
    ignore_end = window_done(cnt, IGNORE_CYCLES);
    trigger_end = window_done(cnt, TRIGGER_CYCLES);
    low_end = window_done(cnt, LOW_CYCLES);
  end

  // Next state and counter; outside POR the band has priority over edges and window ends
  always_comb begin
    next_state = state;
    next_cnt = cnt + cnt_t'(1);
    case (state)
      ST_POR: begin
        if (por_end) begin
          next_cnt = '0;
          // Band applied during the delay is taken only once the delay ends
          if (band_active) begin
            next_state = ST_DISABLED;
          end else begin
            next_state = ST_IGNORE;
          end
        end
      end

      ST_IGNORE: begin
        if (entry_high) begin
          next_cnt = '0;
          next_state = ST_DISABLED;
        end else if (ignore_end) begin
          // Edges during this window are not looked at
          next_cnt = '0;
          next_state = ST_TRIGGER;
        end
      end

      ST_TRIGGER: begin
        // Disable takes precedence over a coincident trigger edge or timeout
        if (entry_high) begin
          next_cnt = '0;
          next_state = ST_DISABLED;
        end else if (trigger_edge) begin
          next_cnt = '0;
        end else if (trigger_end) begin
          next_cnt = '0;
          next_state = ST_LOW;
        end
      end

      ST_LOW: begin
        // The count runs on into the disabled state, so a pulse that is
        // cut by a disable that outlasts it still ends at its normal length
        if (low_end) begin
          next_cnt = '0;
        end
        if (band_active) begin
          next_state = ST_DISABLED;
        end else if (low_end) begin
          next_state = ST_IGNORE;
        end
      end

      ST_DISABLED: begin
        if (!band_active) begin
          // Leaving the band always restarts supervision with an ignore window
          next_cnt = '0;
          next_state = ST_IGNORE;
        end else if (!low_hold || low_end) begin
          // Idle while disabled; the counter is parked to save toggling
          next_cnt = '0;
        end
      end

      default: begin
        // Unused codes fall back to the power-on delay
        next_state = ST_POR;
        next_cnt = '0;
      end
    endcase
  end

  // Reset parks the block at the start of the power-on delay
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_POR;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Output level follows the same states; kept apart from the counter so
  // the release and hold decisions read in one place
  always_comb begin
    next_out_level = out_level;
    next_low_hold = low_hold;
    case (state)
      ST_POR: begin
        // Low for the whole delay, so the controller stays in reset
        if (por_end) begin
          next_out_level = `WD_OUT_HIGH;
        end else begin
          next_out_level = `WD_OUT_LOW;
        end
      end

      ST_IGNORE: begin
        if (entry_high) begin
          next_low_hold = 1'h0;
        end
      end

      ST_TRIGGER: begin
        if (entry_high) begin
          next_low_hold = 1'h0;
        end else if (!trigger_edge && trigger_end) begin
          next_out_level = `WD_OUT_LOW;
        end
      end

      ST_LOW: begin
        if (low_end) begin
          next_out_level = `WD_OUT_HIGH;
          next_low_hold = 1'h0;
        end else if (band_active) begin
          // A short disable keeps the output low until the band is left
          next_low_hold = 1'h1;
        end
      end

      ST_DISABLED: begin
        // Leaving the band releases the output even in mid-pulse
        if (!band_active) begin
          next_out_level = `WD_OUT_HIGH;
          next_low_hold = 1'h0;
        end else if (low_hold && low_end) begin
          next_out_level = `WD_OUT_HIGH;
          next_low_hold = 1'h0;
        end
      end

      default: begin
        next_out_level = `WD_OUT_LOW;
        next_low_hold = 1'h0;
      end
    endcase
  end

  // Output low in reset holds the supervised controller in reset too
  always_ff @(posedge clk) begin
    if (rst) begin
      out_level <= `WD_OUT_LOW;
      low_hold <= 1'h0;
    end else begin
      out_level <= next_out_level;
      low_hold <= next_low_hold;
    end
  end

  // One-cycle marker on the edge where a missed trigger drops the output
  always_comb begin
    next_timeout = 1'h0;
    if (state == ST_TRIGGER && next_state == ST_LOW) begin
      next_timeout = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timeout <= 1'h0;
    end else begin
      timeout <= next_timeout;
    end
  end

  // Disable status lags the filtered band by one register
  always_comb begin
    next_dis_flag = band_active;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dis_flag <= 1'h0;
    end else begin
      dis_flag <= next_dis_flag;
    end
  end

  // Ports read the registers directly
  assign reset_watchdog_out = out_level;
  assign watchdog_disabled = dis_flag;
  assign timeout_event = timeout;
  assign window_state = state;

endmodule

// >>> bench/wd_monitor.sv
`timescale 1ns/1ps
module wd_monitor
  import wdog_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = 40,
  parameter int IGNORE_CYCLES = 30,
  parameter int TRIGGER_CYCLES = 100,
  parameter int LOW_CYCLES = 40,
  parameter int FILTER_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic watchdog_trigger_in,
  input wire logic disable_level_band,
  input wire logic reset_watchdog_out,
  input wire logic watchdog_disabled,
  input wire logic timeout_event,
  input wire wd_state_t window_state
);
  logic trig_q;
  int trig_cnt;
  int next_trig_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Restarts on the pin edge itself; the design sees it a few cycles later, hence the slack below
  always_comb begin
    next_trig_cnt = trig_cnt + 1;
    if (rst || window_state != ST_TRIGGER || (trig_q && !watchdog_trigger_in)) begin
      next_trig_cnt = 0;
    end
  end
  always_ff @(posedge clk) begin
    trig_q <= watchdog_trigger_in;
    trig_cnt <= next_trig_cnt;
  end
  a_por_release: assert property ($past(window_state) == ST_POR && window_state != ST_POR |->
    reset_watchdog_out && $past(window_state == ST_POR, POR_DELAY_CYCLES - 1)) else $error("early release");
  a_rise_state: assert property ($rose(reset_watchdog_out) |->
    window_state inside {ST_IGNORE, ST_DISABLED}) else $error("rise without ignore");
  a_ignore_len: assert property ($rose(window_state == ST_TRIGGER) |->
    $past(window_state == ST_IGNORE, IGNORE_CYCLES - 1)) else $error("short ignore");
  a_timeout_due: assert property (timeout_event |-> !reset_watchdog_out && window_state == ST_LOW &&
    trig_cnt inside {[TRIGGER_CYCLES - 3:TRIGGER_CYCLES + 6]}) else $error("timeout off time");
  a_low_len: assert property ($past(window_state) == ST_LOW && window_state == ST_IGNORE |->
    $past(window_state == ST_LOW, LOW_CYCLES - 1)) else $error("short low pulse");
  a_disabled_high: assert property (watchdog_disabled && $past(watchdog_disabled) |->
    !$fell(reset_watchdog_out)) else $error("fall while disabled");
  a_filter_entry: assert property ($rose(watchdog_disabled) |->
    $past(disable_level_band, FILTER_CYCLES)) else $error("unfiltered entry");
  a_filter_exit: assert property ($fell(watchdog_disabled) |->
    !$past(disable_level_band, FILTER_CYCLES) && window_state == ST_IGNORE) else $error("bad exit");
endmodule

// >>> bench/mcu_model.sv
`timescale 1ns/1ps
module mcu_model (
  input wire logic clk,
  input wire logic serve,
  input wire logic [5:0] period,
  input wire logic park,
  output logic trig,
  output logic band
);
  logic [5:0] cnt;
  initial begin
    trig = 1'h1;
    band = 1'h0;
    cnt = 6'h00;
  end
  always @(negedge clk) begin
    band <= park && !serve;
    cnt <= cnt + 6'h01;
    // Period of at least 3 keeps each phase long enough, and at most 42 keeps both phases of one cycle inside the window
    if (serve && cnt >= period) begin
      trig <= !trig;
      cnt <= 6'h00;
    end
  end
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import wdog_pkg::*;
  typedef struct {logic [1:0] v; int t;} note_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic serve = 1'h0;
  logic park = 1'h0;
  logic tp = 1'h1;
  logic [5:0] period = 6'h03;
  logic [1:0] prev = 2'h0;
  logic trig, band, out, dis, tmo;
  wd_state_t st;
  int err_total = 0, checks_done = 0, cyc = 0, lf = 0, seed = 32'hEC674002;
  note_t q[$];
  note_t n;
  initial forever #2 clk = !clk;
  mcu_model mcu (.clk(clk), .serve(serve), .period(period), .park(park), .trig(trig), .band(band));
  window_watchdog #(.POR_DELAY_CYCLES(40), .IGNORE_CYCLES(30), .TRIGGER_CYCLES(100), .LOW_CYCLES(40),
    .FILTER_CYCLES(10)) DUT (.clk(clk), .rst(rst), .watchdog_trigger_in(trig), .disable_level_band(band),
    .reset_watchdog_out(out), .watchdog_disabled(dis), .timeout_event(tmo), .window_state(st));
  // Each output change takes the oldest note; a change nobody expected meets a dummy note and fails
  always @(negedge clk) begin
    if (rst) begin
      cyc = 0;
      prev = 2'h0;
    end else begin
      cyc++;
      if (tp && !trig) lf = cyc;
      tp = trig;
      if ({out, dis} !== prev) begin
        n = '{2'h0, -99};
        if (q.size() > 0) n = q.pop_front();
        `CHK("out_dis", n.v, {out, dis})
        `CHK("when", 1'b1, cyc >= n.t - 5 && cyc <= n.t + 5)
        if (prev[1] && !out) `CHK("timeout", 1'b1, tmo)
        if (prev[1] && !out) `CHK("state", ST_LOW, st)
        prev = {out, dis};
      end
    end
  end
  task ex(input logic [1:0] v, input int t);
    q.push_back('{v, t});
  endtask
  task at(input int t);
    while (cyc < t) @(negedge clk);
  endtask
  task do_reset();
    @(negedge clk);
    rst = 1'h1;
    serve = 1'h0;
    park = 1'h0;
    `CHK("left", 1'b1, q.size() == 0)
    q.delete();
    repeat (10) @(negedge clk);
    rst = 1'h0;
  endtask
  task tally_and_finish();
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    ex(2'h2, 40);
    ex(2'h0, 170);
    ex(2'h2, 210);
    ex(2'h0, 340);
    ex(2'h2, 380);
    at(390);
    do_reset();
    ex(2'h2, 40);
    serve = 1'h1;
    // Edges during power-on and ignore are served too; they must change nothing
    repeat (12) begin
      period = 6'h03 + 6'($unsigned($random(seed)) % 40);
      repeat (50) @(negedge clk);
    end
    serve = 1'h0;
    repeat (2) @(negedge clk);
    ex(2'h0, lf + 104);
    ex(2'h2, lf + 144);
    at(lf + 150);
    do_reset();
    ex(2'h2, 40);
    ex(2'h3, 115);
    ex(2'h2, 175);
    ex(2'h0, 304);
    at(80);
    park = 1'h1;
    at(85);
    park = 1'h0;
    at(100);
    park = 1'h1;
    at(160);
    park = 1'h0;
    at(310);
    do_reset();
    ex(2'h2, 40);
    ex(2'h0, 170);
    ex(2'h1, 190);
    ex(2'h3, 210);
    ex(2'h2, 265);
    ex(2'h0, 394);
    at(175);
    park = 1'h1;
    at(250);
    park = 1'h0;
    at(400);
    do_reset();
    ex(2'h2, 40);
    ex(2'h0, 170);
    ex(2'h1, 180);
    ex(2'h2, 200);
    ex(2'h0, 329);
    at(165);
    park = 1'h1;
    at(185);
    park = 1'h0;
    at(335);
    do_reset();
    tally_and_finish();
  end
endmodule
bind window_watchdog wd_monitor #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES), .IGNORE_CYCLES(IGNORE_CYCLES),
  .TRIGGER_CYCLES(TRIGGER_CYCLES), .LOW_CYCLES(LOW_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)) mon (.clk, .rst,
  .watchdog_trigger_in, .disable_level_band, .reset_watchdog_out, .watchdog_disabled, .timeout_event, .window_state);
